// file: core/evj_pkg.sv
// constants, field layouts and types of the event jump sequencer
// assumes a 50 MHz system clock; shared by the detector, the sequencer and the bench
package evj_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int ENTRY_N = 256;
	localparam int EVT_N   = 32;
	localparam int IO_N    = 16;

	// ------------------------------------------------------------
	// register map (word per address)
	// ------------------------------------------------------------
	localparam logic [9:0] A_SEL_BASE = 10'h000;
	localparam logic [9:0] A_EVT_BASE = 10'h100;
	localparam logic [9:0] A_STATUS   = 10'h200;
	localparam logic [9:0] A_IO_LEVEL = 10'h201;
	localparam logic [1:0] F_NEXT     = 2'h0;
	localparam logic [1:0] F_DWELL    = 2'h1;
	localparam logic [1:0] F_TRIG     = 2'h2;
	localparam logic [1:0] F_COUNT    = 2'h3;
	localparam int SEL_LO_LSB = 0;
	localparam int SEL_HI_LSB = 8;
	localparam int NEXT_LSB   = 0;
	localparam int LINK_LSB   = 16;
	localparam int IO_LSB     = 0;
	localparam int TYPE_LSB   = 8;

	// ------------------------------------------------------------
	// reset values and encodings
	// ------------------------------------------------------------
	localparam logic [5:0]  SEL_RST   = 6'h3F;
	localparam logic [1:0]  LINK_RST  = 2'h0;
	localparam logic [8:0]  NEXT_RST  = 9'h100;
	localparam logic [15:0] DWELL_RST = 16'h0000;
	localparam logic [7:0]  IO_RST    = 8'h00;
	localparam logic [3:0]  TYPE_RST  = 4'h0;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [8:0]  NEXT_STOP = 9'h100;
	localparam logic [8:0]  NEXT_P2   = 9'h1FE;
	localparam logic [8:0]  NEXT_P1   = 9'h1FF;

	localparam logic [3:0] T_NONE     = 4'h0;
	localparam logic [3:0] T_ON_CCUM  = 4'h1;
	localparam logic [3:0] T_ON_MS    = 4'h2;
	localparam logic [3:0] T_OFF_CCUM = 4'h3;
	localparam logic [3:0] T_OFF_MS   = 4'h4;
	localparam logic [3:0] T_ON_EDGE  = 4'h5;
	localparam logic [3:0] T_OFF_EDGE = 4'h6;
	localparam logic [3:0] T_ON_CUM   = 4'h7;
	localparam logic [3:0] T_OFF_CUM  = 4'h8;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_NS         = 1000000;
	localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_WATCH = 3'h1,
		ST_DWELL = 3'h2,
		ST_JUMP  = 3'h4
	} state_t;
endpackage : evj_pkg

// file: core/evt_slot_if.sv
// carrier between the sequencer and one trigger detector
// assumes both ends share i_clk
`timescale 1ns/1ps
interface evt_slot_if;
	logic [3:0]  typ;
	logic [15:0] cnt;
	logic        lvl;
	logic        clr;
	logic        run;
	logic        tick;
	logic        hit;
	modport ctrl (output typ, output cnt, output lvl, output clr, output run, output tick, input hit);
	modport det  (input typ, input cnt, input lvl, input clr, input run, input tick, output hit);
endinterface : evt_slot_if

// file: core/trig_detect.sv
// trigger detector for one event slot: timed, cumulative and edge types
// assumes lvl is already synchronised and filtered, tick is 1 ms
`timescale 1ns/1ps
module trig_detect (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_ce,
	evt_slot_if.det   s
);
	logic [15:0] acc_q, acc_d;
	logic [15:0] ecnt_q, ecnt_d;
	logic        prev_q, prev_d;
	logic        want_on, plain, cum, edg, at_lvl;
	logic [15:0] need;

	always_comb begin
		want_on = (s.typ == evj_pkg::T_ON_CCUM) || (s.typ == evj_pkg::T_ON_MS) ||
		          (s.typ == evj_pkg::T_ON_EDGE) || (s.typ == evj_pkg::T_ON_CUM);
		plain   = (s.typ == evj_pkg::T_ON_MS) || (s.typ == evj_pkg::T_OFF_MS);
		cum     = (s.typ == evj_pkg::T_ON_CCUM) || (s.typ == evj_pkg::T_OFF_CCUM) ||
		          (s.typ == evj_pkg::T_ON_CUM) || (s.typ == evj_pkg::T_OFF_CUM);
		edg     = (s.typ == evj_pkg::T_ON_EDGE) || (s.typ == evj_pkg::T_OFF_EDGE);
		at_lvl  = (s.lvl == want_on); // RULE11
		need    = (s.cnt == 16'h0000) ? 16'h0001 : s.cnt;
		acc_d   = acc_q;
		ecnt_d  = ecnt_q;
		prev_d  = s.lvl;
		if (s.clr) begin
			acc_d  = 16'h0000; // RULE13
			ecnt_d = 16'h0000; // RULE13
		end else if (s.run) begin
			if (plain && !at_lvl)
				acc_d = 16'h0000; // RULE12
			else if (at_lvl && s.tick && acc_q < s.cnt)
				acc_d = acc_q + 16'h0001; // RULE12
			if (edg && s.lvl != prev_q && at_lvl && ecnt_q != 16'hFFFF)
				ecnt_d = ecnt_q + 16'h0001; // RULE10
		end
		s.hit = 1'b0;
		if (s.run && !s.clr) begin
			if (edg)
				s.hit = ecnt_q >= need; // RULE10
			else if (plain)
				s.hit = at_lvl && acc_q >= s.cnt; // RULE10
			else if (cum)
				s.hit = acc_q >= s.cnt && (at_lvl || s.cnt != 16'h0000); // RULE12
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			acc_q  <= 16'h0000;
			ecnt_q <= 16'h0000;
			prev_q <= 1'b0;
		end else if (i_ce) begin
			acc_q  <= acc_d;
			ecnt_q <= ecnt_d;
			prev_q <= prev_d;
		end
	end
endmodule : trig_detect

// file: core/dwell_timer.sv
// millisecond dwell countdown after a detected event
// assumes i_tick is a one-cycle pulse every millisecond
`timescale 1ns/1ps
module dwell_timer (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic        i_load,
	input  wire logic        i_abort,
	input  wire logic [15:0] i_ms,
	input  wire logic        i_tick,
	output logic             o_busy,
	output logic             o_done
);
	logic [15:0] rem_q, rem_d;
	logic        busy_q, busy_d;

	always_comb begin
		rem_d  = rem_q;
		busy_d = busy_q;
		o_done = busy_q && rem_q == 16'h0000;
		if (i_abort) begin
			busy_d = 1'b0;
		end else if (i_load) begin
			rem_d  = i_ms;
			busy_d = 1'b1;
		end else if (o_done) begin
			busy_d = 1'b0;
		end else if (busy_q && i_tick) begin
			rem_d = rem_q - 16'h0001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rem_q  <= 16'h0000;
			busy_q <= 1'b0;
		end else if (i_ce) begin
			rem_q  <= rem_d;
			busy_q <= busy_d;
		end
	end

	assign o_busy = busy_q;
endmodule : dwell_timer

// file: core/event_jump_sequencer.sv
// event jump logic of a stored-data sequencer: event tables, detection, dwell, jump
// assumes the sequencer drives run, entry and entry_start from i_clk; i_io are pins
// Summary of operation
// RULE1 - while linked or looped operation runs, a detected enabled event abandons the step and jumps to its target.
// RULE2 - every data entry holds a low and a high event selection watched while that entry executes.
// RULE3 - when low and high events are detected together the high one is taken and the low one ignored.
// RULE4 - a selection is -1 for disabled or 0 to 31 for an event record, and both reset to -1.
// RULE5 - each event record carries a link mode 0 none, 1 manual, 2 automatic, 3 continuous, reset 0.
// RULE6 - the event next field is -256 stop, -2 entry plus two, -1 entry plus one, 0 to 255 absolute, reset -256.
// RULE7 - after detection the block waits the event dwell of 0 to 65535 ms before continuing, reset 0.
// RULE8 - each event record selects its trigger signal, 0 meaning none, which is the reset value.
// RULE9 - trigger types are 0 off, 1/3 calculated cumulative on/off, 2/4 on/off ms, 5/6 edges, 7/8 cumulative.
// RULE10 - the count 0 to 65535 is milliseconds for timed types and detections for edge types, reset 0.
// RULE11 - a branch is decided from the on or off state of the chosen signal as the trigger type defines.
// RULE12 - plain ms types restart their timer when the level leaves; cumulative types keep adding time.
// RULE13 - timers and edge counters clear whenever a new data entry begins.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module event_jump_sequencer #(
	parameter int CYC_PER_MS = evj_pkg::CYC_PER_MS
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic [9:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic        i_seq_run,
	input  wire logic        i_entry_start,
	input  wire logic [7:0]  i_entry,
	input  wire logic [15:0] i_io,
	output logic             o_jump,
	output logic             o_jump_stop,
	output logic      [7:0]  o_jump_target,
	output logic      [1:0]  o_jump_link,
	output logic             o_dwell_busy,
	output logic             o_evt_high
);
	// ------------------------------------------------------------
	// tables
	// ------------------------------------------------------------
	logic [5:0]  sel_lo_q [evj_pkg::ENTRY_N];
	logic [5:0]  sel_hi_q [evj_pkg::ENTRY_N];
	logic [1:0]  ev_link_q  [evj_pkg::EVT_N];
	logic [8:0]  ev_next_q  [evj_pkg::EVT_N];
	logic [15:0] ev_dwell_q [evj_pkg::EVT_N];
	logic [7:0]  ev_io_q    [evj_pkg::EVT_N];
	logic [3:0]  ev_type_q  [evj_pkg::EVT_N];
	logic [15:0] ev_cnt_q   [evj_pkg::EVT_N];

	logic        is_sel, is_evt;
	logic [7:0]  a_entry;
	logic [4:0]  a_evt;
	logic [1:0]  a_fld;

	always_comb begin
		a_entry = i_addr[7:0];
		a_evt   = i_addr[6:2];
		a_fld   = i_addr[1:0];
		is_sel  = 1'b0;
		is_evt  = 1'b0;
		if (i_addr[9:8] == evj_pkg::A_SEL_BASE[9:8])
			is_sel = 1'b1;
		else if (i_addr[9:7] == evj_pkg::A_EVT_BASE[9:7])
			is_evt = 1'b1;
	end

	// table storage writes straight into the arrays; too large for a _d copy
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int k = 0; k < evj_pkg::ENTRY_N; k++) begin
				sel_lo_q[k] <= evj_pkg::SEL_RST; // RULE4
				sel_hi_q[k] <= evj_pkg::SEL_RST; // RULE4
			end
			for (int k = 0; k < evj_pkg::EVT_N; k++) begin
				ev_link_q[k]  <= evj_pkg::LINK_RST; // RULE5
				ev_next_q[k]  <= evj_pkg::NEXT_RST; // RULE6
				ev_dwell_q[k] <= evj_pkg::DWELL_RST; // RULE7
				ev_io_q[k]    <= evj_pkg::IO_RST; // RULE8
				ev_type_q[k]  <= evj_pkg::TYPE_RST; // RULE9
				ev_cnt_q[k]   <= evj_pkg::COUNT_RST; // RULE10
			end
		end else if (i_ce && i_wr) begin
			if (is_sel) begin
				sel_lo_q[a_entry] <= i_wdata[evj_pkg::SEL_LO_LSB +: 6]; // RULE2
				sel_hi_q[a_entry] <= i_wdata[evj_pkg::SEL_HI_LSB +: 6]; // RULE2
			end else if (is_evt) begin
				case (a_fld)
					evj_pkg::F_NEXT: begin
						ev_next_q[a_evt] <= i_wdata[evj_pkg::NEXT_LSB +: 9]; // RULE6
						ev_link_q[a_evt] <= i_wdata[evj_pkg::LINK_LSB +: 2]; // RULE5
					end
					evj_pkg::F_DWELL: begin
						ev_dwell_q[a_evt] <= i_wdata[15:0]; // RULE7
					end
					evj_pkg::F_TRIG: begin
						ev_io_q[a_evt]   <= i_wdata[evj_pkg::IO_LSB +: 8]; // RULE8
						ev_type_q[a_evt] <= i_wdata[evj_pkg::TYPE_LSB +: 4]; // RULE9
					end
					default: begin
						ev_cnt_q[a_evt] <= i_wdata[15:0]; // RULE10
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers and agreement filter
	// ------------------------------------------------------------
	logic [15:0] s1_q, s2_q, s3_q, filt_q, filt_d;

	generate
		for (genvar b = 0; b < evj_pkg::IO_N; b++) begin : g_filt
			// a change counts only once the last two stages agree
			assign filt_d[b] = (s2_q[b] == s3_q[b]) ? s3_q[b] : filt_q[b];
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s1_q   <= 16'h0000;
			s2_q   <= 16'h0000;
			s3_q   <= 16'h0000;
			filt_q <= 16'h0000;
		end else if (i_ce) begin
			s1_q   <= i_io;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= filt_d;
		end
	end

	// ------------------------------------------------------------
	// millisecond tick
	// ------------------------------------------------------------
	logic [15:0] ms_q, ms_d;
	logic        tick;

	always_comb begin
		tick = ms_q == 16'(CYC_PER_MS - 1);
		ms_d = tick ? 16'h0000 : ms_q + 16'h0001;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			ms_q <= 16'h0000;
		else if (i_ce)
			ms_q <= ms_d;
	end

	// ------------------------------------------------------------
	// slot set-up for the executing entry
	// ------------------------------------------------------------
	evj_pkg::state_t state_q, state_d;
	evt_slot_if slot_lo ();
	evt_slot_if slot_hi ();

	logic [5:0] cur_lo, cur_hi;
	logic       lo_on, hi_on;

	// unknown signal numbers and types fall back to disabled
	function automatic logic [3:0] eff_type(input logic [4:0] e);
		logic [7:0] io;
		io = ev_io_q[e];
		if (io == 8'h00 || io > 8'(evj_pkg::IO_N) || ev_type_q[e] > evj_pkg::T_OFF_CUM)
			return evj_pkg::T_NONE; // RULE8
		return ev_type_q[e]; // RULE9
	endfunction : eff_type

	function automatic logic level_of(input logic [4:0] e, input logic [15:0] f);
		logic [7:0] io;
		io = ev_io_q[e] - 8'h01;
		return f[io[3:0]]; // RULE11
	endfunction : level_of

	always_comb begin
		cur_lo = sel_lo_q[i_entry]; // RULE2
		cur_hi = sel_hi_q[i_entry]; // RULE2
		lo_on  = !cur_lo[5]; // RULE4
		hi_on  = !cur_hi[5]; // RULE4
		slot_lo.typ  = lo_on ? eff_type(cur_lo[4:0]) : evj_pkg::T_NONE;
		slot_hi.typ  = hi_on ? eff_type(cur_hi[4:0]) : evj_pkg::T_NONE;
		slot_lo.cnt  = ev_cnt_q[cur_lo[4:0]];
		slot_hi.cnt  = ev_cnt_q[cur_hi[4:0]];
		slot_lo.lvl  = level_of(cur_lo[4:0], filt_q);
		slot_hi.lvl  = level_of(cur_hi[4:0], filt_q);
		slot_lo.clr  = i_entry_start || !i_seq_run; // RULE13
		slot_hi.clr  = i_entry_start || !i_seq_run; // RULE13
		slot_lo.run  = i_seq_run && state_q == evj_pkg::ST_WATCH; // RULE1
		slot_hi.run  = i_seq_run && state_q == evj_pkg::ST_WATCH; // RULE1
		slot_lo.tick = tick;
		slot_hi.tick = tick;
	end

	trig_detect u_det_lo (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_ce  (i_ce),
		.s     (slot_lo)
	);

	trig_detect u_det_hi (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_ce  (i_ce),
		.s     (slot_hi)
	);

	// ------------------------------------------------------------
	// jump sequencing
	// ------------------------------------------------------------
	logic [4:0]  evt_q, evt_d;
	logic        high_q, high_d;
	logic [7:0]  base_q, base_d;
	logic        jump_q, jump_d;
	logic        stop_q, stop_d;
	logic [7:0]  tgt_q, tgt_d;
	logic [1:0]  link_q, link_d;
	logic        load, dwell_done;
	logic [8:0]  calc;
	logic [8:0]  nxt;

	always_comb begin
		state_d = state_q;
		evt_d   = evt_q;
		high_d  = high_q;
		base_d  = base_q;
		jump_d  = 1'b0;
		stop_d  = stop_q;
		tgt_d   = tgt_q;
		link_d  = link_q;
		load    = 1'b0;
		nxt     = ev_next_q[evt_q];
		calc    = {1'b0, nxt[7:0]};
		if (nxt == evj_pkg::NEXT_P1)
			calc = {1'b0, base_q} + 9'h001; // RULE6
		else if (nxt == evj_pkg::NEXT_P2)
			calc = {1'b0, base_q} + 9'h002; // RULE6
		else if (nxt[8])
			calc = evj_pkg::NEXT_STOP; // RULE6
		case (state_q)
			evj_pkg::ST_WATCH: begin
				if (slot_hi.hit) begin
					evt_d   = cur_hi[4:0]; // RULE3
					high_d  = 1'b1;
					base_d  = i_entry;
					load    = 1'b1;
					state_d = evj_pkg::ST_DWELL; // RULE1
				end else if (slot_lo.hit) begin
					evt_d   = cur_lo[4:0];
					high_d  = 1'b0;
					base_d  = i_entry;
					load    = 1'b1;
					state_d = evj_pkg::ST_DWELL; // RULE1
				end
			end
			evj_pkg::ST_DWELL: begin
				if (!i_seq_run) begin
					state_d = evj_pkg::ST_WATCH;
				end else if (dwell_done) begin
					jump_d  = 1'b1; // RULE7
					stop_d  = calc[8];
					tgt_d   = calc[7:0];
					link_d  = ev_link_q[evt_q]; // RULE5
					state_d = evj_pkg::ST_JUMP;
				end
			end
			evj_pkg::ST_JUMP: begin
				// hold off until the sequencer leaves the abandoned entry
				if (i_entry_start || !i_seq_run)
					state_d = evj_pkg::ST_WATCH;
			end
			default: begin
				state_d = evj_pkg::ST_WATCH;
			end
		endcase
	end

	dwell_timer u_dwell (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_load  (load),
		.i_abort (!i_seq_run),
		.i_ms    (ev_dwell_q[evt_d]),
		.i_tick  (tick),
		.o_busy  (o_dwell_busy),
		.o_done  (dwell_done)
	);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_q <= evj_pkg::ST_WATCH;
			evt_q   <= 5'h00;
			high_q  <= 1'b0;
			base_q  <= 8'h00;
			jump_q  <= 1'b0;
			stop_q  <= 1'b0;
			tgt_q   <= 8'h00;
			link_q  <= evj_pkg::LINK_RST;
		end else if (i_ce) begin
			state_q <= state_d;
			evt_q   <= evt_d;
			high_q  <= high_d;
			base_q  <= base_d;
			jump_q  <= jump_d;
			stop_q  <= stop_d;
			tgt_q   <= tgt_d;
			link_q  <= link_d;
		end
	end

	assign o_jump        = jump_q;
	assign o_jump_stop   = stop_q;
	assign o_jump_target = tgt_q;
	assign o_jump_link   = link_q;
	assign o_evt_high    = high_q;

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	logic [31:0] rd_q, rd_d;

	always_comb begin
		rd_d = 32'h0000_0000;
		if (!i_rd) begin
			rd_d = 32'h0000_0000;
		end else if (is_sel) begin
			rd_d[evj_pkg::SEL_LO_LSB +: 6] = sel_lo_q[a_entry];
			rd_d[evj_pkg::SEL_HI_LSB +: 6] = sel_hi_q[a_entry];
		end else if (is_evt && a_fld == evj_pkg::F_NEXT) begin
			rd_d[evj_pkg::NEXT_LSB +: 9] = ev_next_q[a_evt];
			rd_d[evj_pkg::LINK_LSB +: 2] = ev_link_q[a_evt];
		end else if (is_evt && a_fld == evj_pkg::F_DWELL) begin
			rd_d[15:0] = ev_dwell_q[a_evt];
		end else if (is_evt && a_fld == evj_pkg::F_TRIG) begin
			rd_d[evj_pkg::IO_LSB +: 8]   = ev_io_q[a_evt];
			rd_d[evj_pkg::TYPE_LSB +: 4] = ev_type_q[a_evt];
		end else if (is_evt) begin
			rd_d[15:0] = ev_cnt_q[a_evt];
		end else if (i_addr == evj_pkg::A_STATUS) begin
			rd_d = {8'h00, tgt_q, link_q, stop_q, high_q, evt_q, 3'h0, o_dwell_busy, state_q};
		end else if (i_addr == evj_pkg::A_IO_LEVEL) begin
			rd_d[15:0] = filt_q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			rd_q <= 32'h0000_0000;
		else if (i_ce)
			rd_q <= rd_d;
	end

	assign o_rdata = rd_q;
endmodule : event_jump_sequencer

// file: verif/evj_monitor.sv
// port checker for the event jump sequencer
// assumes i_ce only drops while the block is idle
`timescale 1ns/1ps
module evj_monitor #(
	parameter int CYC_PER_MS = 10
) (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_ce,
	input wire logic [9:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic        i_seq_run,
	input wire logic        i_entry_start,
	input wire logic [7:0]  i_entry,
	input wire logic [15:0] i_io,
	input wire logic        o_jump,
	input wire logic        o_jump_stop,
	input wire logic [7:0]  o_jump_target,
	input wire logic [1:0]  o_jump_link,
	input wire logic        o_dwell_busy,
	input wire logic        o_evt_high
);
	// ----
	// jump taken, no second one until a new entry
	// ----
	logic armed_q;
	logic armed_d;
	always_comb begin
		armed_d = armed_q;
		if (o_jump)
			armed_d = 1'b1;
		else if (i_entry_start || !i_seq_run)
			armed_d = 1'b0;
	end
	always_ff @(posedge i_clk) begin
		armed_q <= i_rst ? 1'b0 : armed_d;
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence run_held_s;
		$past(i_seq_run, 2) && $past(i_seq_run);
	endsequence
	sequence run_low_s;
		!i_seq_run ##1 !i_seq_run;
	endsequence

	jump_single_a: assert property (o_jump |=> !o_jump) else $error("jump pulse too long");
	jump_run_a: assert property (o_jump |-> run_held_s) else $error("jump without run");
	rejump_a: assert property (armed_q |-> !o_jump) else $error("second jump in one entry");
	dwell_abort_a: assert property (run_low_s |=> !o_dwell_busy && !o_jump) else $error("dwell kept");
	entry_quiet_a: assert property (i_entry_start |=> !o_jump [*2]) else $error("jump at entry start");
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h00000000) else $error("stray read data");
	target_held_a: assert property (!o_jump |-> $stable(o_jump_target) && $stable(o_jump_stop))
		else $error("target moved");
	// the high flag is taken at detection, together with the dwell start
	link_held_a: assert property (!o_jump |-> $stable(o_jump_link) && ($stable(o_evt_high) || $rose(o_dwell_busy)))
		else $error("link moved");
endmodule : evj_monitor

bind event_jump_sequencer evj_monitor #(.CYC_PER_MS(CYC_PER_MS)) mon_u (
	.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_seq_run(i_seq_run),
	.i_entry_start(i_entry_start), .i_entry(i_entry), .i_io(i_io), .o_jump(o_jump),
	.o_jump_stop(o_jump_stop), .o_jump_target(o_jump_target), .o_jump_link(o_jump_link),
	.o_dwell_busy(o_dwell_busy), .o_evt_high(o_evt_high));

// file: verif/io_host.sv
// host model: sequencer run/entry lines and trigger pins
// assumes the bench calls its tasks from one process
`timescale 1ns/1ps
module io_host (
	input  wire logic        i_clk,
	output logic      [15:0] o_io,
	output logic             o_seq_run,
	output logic             o_entry_start,
	output logic      [7:0]  o_entry
);
	initial begin
		o_io = 16'h0000;
		o_seq_run = 1'b0;
		o_entry_start = 1'b0;
		o_entry = 8'h00;
	end
	task automatic pin(input int k, input logic v);
		@(posedge i_clk);
		o_io[k-1] <= v;
	endtask : pin
	task automatic begin_entry(input logic [7:0] e);
		@(posedge i_clk);
		o_seq_run <= 1'b1;
		o_entry <= e;
		o_entry_start <= 1'b1;
		@(posedge i_clk);
		o_entry_start <= 1'b0;
	endtask : begin_entry
	task automatic halt();
		@(posedge i_clk);
		o_seq_run <= 1'b0;
	endtask : halt
endmodule : io_host

// file: verif/tb_top.sv
// self-checking bench for the event jump sequencer
// assumes 10 cycles per ms so timed triggers stay short
`timescale 1ns/1ps
module tb_top;
	logic        clk;
	logic        rst = 1'b1;
	logic [9:0]  addr = 10'h000;
	logic [31:0] wdata = 32'h00000000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        ce = 1'b1;
	logic [31:0] rdata;
	logic [15:0] io;
	logic        run;
	logic        est;
	logic [7:0]  entry;
	logic        jump;
	logic        stop;
	logic [7:0]  target;
	logic [1:0]  link;
	logic        busy;
	logic        high;
	int          fail_count = 0;
	int          tests_run = 0;
	int          cycles = 0;

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	io_host host_u (.i_clk(clk), .o_io(io), .o_seq_run(run), .o_entry_start(est), .o_entry(entry));
	event_jump_sequencer #(.CYC_PER_MS(10)) dut_u (
		.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_seq_run(run), .i_entry_start(est), .i_entry(entry),
		.i_io(io), .o_jump(jump), .o_jump_stop(stop), .o_jump_target(target),
		.o_jump_link(link), .o_dwell_busy(busy), .o_evt_high(high));

	// ----
	// shared tasks
	// ----
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wreg(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [9:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask : rreg
	task automatic evt(input int e, input logic [8:0] nx, input logic [1:0] lk, input logic [15:0] dw,
		input logic [7:0] pn, input logic [3:0] ty, input logic [15:0] ct);
		logic [9:0] b;
		b = evj_pkg::A_EVT_BASE + 10'(e * 4);
		wreg(b, {14'h0000, lk, 7'h00, nx});
		wreg(b + 10'h001, {16'h0000, dw});
		wreg(b + 10'h002, {20'h00000, ty, pn});
		wreg(b + 10'h003, {16'h0000, ct});
	endtask : evt
	task automatic sel(input logic [7:0] n, input logic [5:0] lo, input logic [5:0] hi);
		wreg(evj_pkg::A_SEL_BASE + 10'(n), {18'h00000, hi, 2'h0, lo});
	endtask : sel
	task automatic wait_jump(input int n, output logic got, output int cyc);
		got = 1'b0;
		for (cyc = 0; cyc < n && !got; cyc++) begin
			@(posedge clk);
			#1 got = (jump === 1'b1);
		end
	endtask : wait_jump

	// ----
	// scenarios
	// ----
	task automatic t_reset();
		rreg(evj_pkg::A_SEL_BASE + 10'h0FF, 32'h00003F3F);
		rreg(evj_pkg::A_EVT_BASE + 10'h07C, 32'h00000100);
		rreg(evj_pkg::A_EVT_BASE + 10'h001, 32'h00000000);
		rreg(evj_pkg::A_EVT_BASE + 10'h002, 32'h00000000);
		rreg(evj_pkg::A_EVT_BASE + 10'h003, 32'h00000000);
		wreg(10'h3FF, 32'hFFFFFFFF);
		rreg(10'h3FF, 32'h00000000);
		// a write while frozen must be dropped
		@(posedge clk);
		ce <= 1'b0;
		wreg(evj_pkg::A_SEL_BASE + 10'h0FE, 32'h00000000);
		@(posedge clk);
		ce <= 1'b1;
		rreg(evj_pkg::A_SEL_BASE + 10'h0FE, 32'h00003F3F);
	endtask : t_reset
	task automatic t_targets();
		logic [8:0] nx [4] = '{9'h100, 9'h1FE, 9'h1FF, 9'h007};
		logic [7:0] tg [4] = '{8'h00, 8'h0C, 8'h0B, 8'h07};
		logic got;
		int cyc;
		sel(8'h0A, 6'h00, 6'h3F);
		for (int i = 0; i < 4; i++) begin
			evt(0, nx[i], 2'(i), 16'h0000, 8'h01, evj_pkg::T_ON_EDGE, 16'h0001);
			host_u.begin_entry(8'h0A);
			host_u.pin(1, 1'b1);
			wait_jump(40, got, cyc);
			check({31'h0, got}, 32'h1);
			check({31'h0, stop}, {31'h0, i == 0});
			if (i != 0) check({24'h0, target}, {24'h0, tg[i]});
			check({30'h0, link}, 32'(i));
			host_u.pin(1, 1'b0);
			host_u.halt();
		end
	endtask : t_targets
	task automatic t_priority();
		logic got;
		int cyc;
		evt(1, 9'h014, 2'h1, 16'h0000, 8'h02, evj_pkg::T_ON_EDGE, 16'h0001);
		evt(2, 9'h01E, 2'h3, 16'h0000, 8'h02, evj_pkg::T_ON_EDGE, 16'h0001);
		sel(8'h05, 6'h01, 6'h02);
		host_u.begin_entry(8'h05);
		host_u.pin(2, 1'b1);
		wait_jump(40, got, cyc);
		check({23'h0, got, target}, 32'h0000011E);
		check({30'h0, high, link[0]}, 32'h3);
		host_u.pin(2, 1'b0);
		host_u.halt();
	endtask : t_priority
	task automatic t_types();
		logic [8:0] act = 9'h0A6;
		logic got;
		int cyc;
		sel(8'h06, 6'h03, 6'h3F);
		for (int ty = 0; ty < 9; ty++) begin
			evt(3, 9'h040, 2'h0, 16'h0000, 8'h03, 4'(ty), 16'h0001);
			host_u.pin(3, !act[ty]);
			repeat (10) @(posedge clk);
			host_u.begin_entry(8'h06);
			host_u.pin(3, act[ty]);
			wait_jump(60, got, cyc);
			check({31'h0, got}, {31'h0, ty != 0});
			host_u.halt();
		end
		host_u.pin(3, 1'b0);
	endtask : t_types
	task automatic t_accum();
		logic got;
		int cyc;
		sel(8'h07, 6'h04, 6'h3F);
		// two pulses: plain restarts, cumulative adds up, two edges fall short of four
		for (int k = 0; k < 3; k++) begin
			evt(4, 9'h050, 2'h0, 16'h0000, 8'h04,
				(k == 0) ? evj_pkg::T_ON_MS : (k == 1) ? evj_pkg::T_ON_CUM : evj_pkg::T_ON_EDGE, 16'h0004);
			host_u.begin_entry(8'h07);
			fork
				begin
					host_u.pin(4, 1'b1);
					repeat (25) @(posedge clk);
					host_u.pin(4, 1'b0);
					repeat (10) @(posedge clk);
					host_u.pin(4, 1'b1);
					repeat (25) @(posedge clk);
					host_u.pin(4, 1'b0);
				end
				wait_jump(110, got, cyc);
			join
			check({31'h0, got}, {31'h0, k == 1});
			host_u.halt();
		end
	endtask : t_accum
	task automatic t_dwell();
		logic got;
		int cyc;
		evt(5, 9'h060, 2'h0, 16'h0003, 8'h05, evj_pkg::T_ON_EDGE, 16'h0001);
		sel(8'h08, 6'h05, 6'h3F);
		host_u.begin_entry(8'h08);
		host_u.pin(5, 1'b1);
		wait_jump(80, got, cyc);
		check({31'h0, got && cyc >= 20 && cyc <= 42}, 32'h1);
		host_u.pin(5, 1'b0);
		host_u.halt();
		host_u.begin_entry(8'h08);
		host_u.pin(5, 1'b1);
		repeat (12) @(posedge clk);
		#1 check({31'h0, busy}, 32'h1);
		host_u.halt();
		wait_jump(60, got, cyc);
		check({30'h0, got, busy}, 32'h0);
		host_u.pin(5, 1'b0);
	endtask : t_dwell

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			conclude();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_targets();
		t_priority();
		t_types();
		t_accum();
		t_dwell();
		conclude();
	end
endmodule : tb_top
